/* File: bru_unit.sv */
// Buffer half-register load/store and atomic read-modify-write unit
`timescale 1ns/1ps
`include "bru_consts.svh"

// Operation
// - Op 35: signed byte, sign-extended, into upper half; lower half kept.
// - Op 36: halfword into bits 15..0; upper half kept.
// - Op 37: halfword into bits 31..16; lower half kept.
// - Op 38: converted 16-bit result into upper half of destination.
// - Op 39: store one converted component taken from upper data half.
// - Op 48: write data word, return previous memory word.
// - Op 49: source word 0, compare word 1; write if equal; return old.
// - Op 50: memory plus data stored; old value returned.
// - Op 51: memory minus data stored; old value returned.
// - Op 52: zero if old below data, else difference; return old.
// - Ops 53/55: signed minimum/maximum stored; old returned.
// - Ops 54/56: unsigned minimum/maximum stored; old returned.
// - Op 60: zero if old >= limit, else old plus one; return old.
// - Op 62: float compare-exchange, NaN never equal, +0 equal to -0.
// - Ops 63/64: float minimum/maximum stored; old in word 0.
// - Op 81: 64-bit compare-exchange, source words 0-1, compare 2-3.
// - Ops 85-88: 64-bit signed/unsigned minimum/maximum; old returned.
module bru_unit
(
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   // Core request
   input  wire logic        i_req_valid,
   input  wire logic [7:0]  i_req_op,
   input  wire logic [31:0] i_req_addr,
   input  wire logic [31:0] i_req_data0,
   input  wire logic [31:0] i_req_data1,
   input  wire logic [31:0] i_req_data2,
   input  wire logic [31:0] i_req_data3,
   input  wire logic [31:0] i_req_dst,
   output logic             o_req_ready,
   // Core response
   output logic             o_resp_valid,
   output logic             o_resp_bad,
   output logic      [31:0] o_resp_data0,
   output logic      [31:0] o_resp_data1,
   // Memory port
   output logic             o_mem_rd,
   output logic             o_mem_wr,
   output logic             o_mem_lock,
   output logic      [31:0] o_mem_addr,
   output logic      [1:0]  o_mem_size,
   output logic      [63:0] o_mem_wdata,
   input  wire logic        i_mem_ack,
   input  wire logic [63:0] i_mem_rdata
);

   bru_pkg::bru_state_t state;
   bru_pkg::bru_state_t next_state;

   // Latched request
   logic [7:0]  op;
   logic [31:0] data0;
   logic [31:0] data1;
   logic [31:0] data2;
   logic [31:0] data3;
   logic [31:0] dst;

   // Decode of the latched opcode
   logic        is_ld_sb_up;
   logic        is_ld_half_lo;
   logic        is_ld_half_up;
   logic        is_ld_conv_up;
   logic        is_load;
   logic        is_store;
   logic        is_atomic;
   logic        is_wide;
   logic        alu_known;
   logic [63:0] alu_new;
   logic [1:0]  access_size;
   logic [31:0] load_result;
   logic [7:0]  rd_byte;
   logic [15:0] rd_half;
   logic        accept;
   logic        rd_done;
   logic        wr_done;

   // Next values of the registered outputs
   logic        next_ready;
   logic        next_resp_valid;
   logic        next_resp_bad;
   logic [31:0] next_resp_data0;
   logic [31:0] next_resp_data1;
   logic        next_mem_rd;
   logic        next_mem_wr;
   logic        next_mem_lock;
   logic [1:0]  next_mem_size;
   logic [63:0] next_mem_wdata;

   bru_alu u_alu
   (
      .i_op    (op),
      .i_old   (i_mem_rdata),
      .i_data0 (data0),
      .i_data1 (data1),
      .i_data2 (data2),
      .i_data3 (data3),
      .o_new   (alu_new),
      .o_known (alu_known)
   );

   // Opcode decode
   assign is_ld_sb_up   = op == `BRU_OP_LD_SB_UPPER;
   assign is_ld_half_lo = op == `BRU_OP_LD_HALF_LOW;
   assign is_ld_half_up = op == `BRU_OP_LD_HALF_UP;
   assign is_ld_conv_up = op == `BRU_OP_LD_CONV_UP;
   assign is_store      = op == `BRU_OP_ST_CONV_UP;
   assign is_load       = is_ld_sb_up || is_ld_half_lo ||
                          is_ld_half_up || is_ld_conv_up;
   assign is_atomic     = alu_known;
   assign is_wide       = op >= `BRU_OP_WIDE_FIRST;

   // Access size
   assign access_size = is_ld_sb_up ? `BRU_SZ_BYTE :
                        (is_load || is_store) ? `BRU_SZ_HALF :
                        is_wide ? `BRU_SZ_DWORD : `BRU_SZ_WORD;

   // Load merge into the destination register
   assign rd_byte = i_mem_rdata[7:0];
   assign rd_half = i_mem_rdata[15:0];
   assign load_result =
      is_ld_sb_up   ? {{8{rd_byte[7]}}, rd_byte, dst[15:0]} :
      is_ld_half_lo ? {dst[31:16], rd_half} :
      is_ld_half_up ? {rd_half, dst[15:0]} :
                      {rd_half, dst[15:0]};

   // Handshake events
   assign accept  = (state == bru_pkg::BRU_IDLE) && i_req_valid && o_req_ready;
   assign rd_done = o_mem_rd && i_mem_ack;
   assign wr_done = o_mem_wr && i_mem_ack;

   // Sequencer
   always_comb
   begin
      next_state      = state;
      next_ready      = o_req_ready;
      next_resp_valid = 1'b0;
      next_resp_bad   = o_resp_bad;
      next_resp_data0 = o_resp_data0;
      next_resp_data1 = o_resp_data1;
      next_mem_rd     = o_mem_rd;
      next_mem_wr     = o_mem_wr;
      next_mem_lock   = o_mem_lock;
      next_mem_size   = o_mem_size;
      next_mem_wdata  = o_mem_wdata;
      case (state)
         bru_pkg::BRU_IDLE:
         begin
            if (accept)
            begin
               next_ready = 1'b0;
               next_state = bru_pkg::BRU_ISSUE;
            end
         end
         bru_pkg::BRU_ISSUE:
         begin
            next_mem_size   = access_size;
            next_resp_bad   = 1'b0;
            next_resp_data0 = `BRU_RST_WORD;
            next_resp_data1 = `BRU_RST_WORD;
            if (is_store)
            begin
               next_mem_wdata = {48'h0, data0[31:16]};
               next_mem_wr    = 1'b1;
               next_state     = bru_pkg::BRU_WRITE;
            end
            else if (is_load || is_atomic)
            begin
               next_mem_rd   = 1'b1;
               next_mem_lock = is_atomic;
               next_state    = bru_pkg::BRU_READ;
            end
            else
            begin
               next_resp_bad   = 1'b1;
               next_resp_valid = 1'b1;
               next_state      = bru_pkg::BRU_RESP;
            end
         end
         bru_pkg::BRU_READ:
         begin
            if (rd_done)
            begin
               next_mem_rd = 1'b0;
               if (is_atomic)
               begin
                  // Old value returned, new value written under lock
                  next_resp_data0 = i_mem_rdata[31:0];
                  next_resp_data1 = is_wide ? i_mem_rdata[63:32]
                                            : `BRU_RST_WORD;
                  next_mem_wdata  = is_wide ? alu_new
                                  : {32'h0, alu_new[31:0]};
                  next_mem_wr     = 1'b1;
                  next_state      = bru_pkg::BRU_WRITE;
               end
               else
               begin
                  next_resp_data0 = load_result;
                  next_resp_valid = 1'b1;
                  next_state      = bru_pkg::BRU_RESP;
               end
            end
         end
         bru_pkg::BRU_WRITE:
         begin
            if (wr_done)
            begin
               next_mem_wr     = 1'b0;
               next_mem_lock   = 1'b0;
               next_resp_valid = 1'b1;
               next_state      = bru_pkg::BRU_RESP;
            end
         end
         bru_pkg::BRU_RESP:
         begin
            next_ready = 1'b1;
            next_state = bru_pkg::BRU_IDLE;
         end
         default:
         begin
            next_state = bru_pkg::BRU_IDLE;
         end
      endcase
   end

   // State and handshake flops
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state        <= bru_pkg::BRU_IDLE;
         o_req_ready  <= 1'b1;
         o_resp_valid <= 1'b0;
         o_resp_bad   <= 1'b0;
         o_mem_rd     <= 1'b0;
         o_mem_wr     <= 1'b0;
         o_mem_lock   <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         o_req_ready  <= next_ready;
         o_resp_valid <= next_resp_valid;
         o_resp_bad   <= next_resp_bad;
         o_mem_rd     <= next_mem_rd;
         o_mem_wr     <= next_mem_wr;
         o_mem_lock   <= next_mem_lock;
      end
   end

   // Data flops
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_resp_data0 <= `BRU_RST_WORD;
         o_resp_data1 <= `BRU_RST_WORD;
         o_mem_size   <= `BRU_SZ_BYTE;
         o_mem_wdata  <= `BRU_RST_DWORD;
      end
      else
      begin
         o_resp_data0 <= next_resp_data0;
         o_resp_data1 <= next_resp_data1;
         o_mem_size   <= next_mem_size;
         o_mem_wdata  <= next_mem_wdata;
      end
   end

   // Request capture
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         op         <= 8'h00;
         o_mem_addr <= `BRU_RST_WORD;
         data0      <= `BRU_RST_WORD;
         data1      <= `BRU_RST_WORD;
         data2      <= `BRU_RST_WORD;
         data3      <= `BRU_RST_WORD;
         dst        <= `BRU_RST_WORD;
      end
      else if (accept)
      begin
         op         <= i_req_op;
         o_mem_addr <= i_req_addr;
         data0      <= i_req_data0;
         data1      <= i_req_data1;
         data2      <= i_req_data2;
         data3      <= i_req_data3;
         dst        <= i_req_dst;
      end
   end

endmodule

/* File: bru_consts.svh */
// Opcodes, access sizes and fixed values of the buffer atomic unit
`ifndef BRU_CONSTS_SVH
`define BRU_CONSTS_SVH

// Half-register loads and converted store
`define BRU_OP_LD_SB_UPPER   8'h23
`define BRU_OP_LD_HALF_LOW   8'h24
`define BRU_OP_LD_HALF_UP    8'h25
`define BRU_OP_LD_CONV_UP    8'h26
`define BRU_OP_ST_CONV_UP    8'h27

// 32-bit atomics
`define BRU_OP_XCHG          8'h30
`define BRU_OP_CMPXCHG       8'h31
`define BRU_OP_SUM           8'h32
`define BRU_OP_DIFF          8'h33
`define BRU_OP_CLAMP_DIFF    8'h34
`define BRU_OP_SMIN          8'h35
`define BRU_OP_UMIN          8'h36
`define BRU_OP_SMAX          8'h37
`define BRU_OP_UMAX          8'h38
`define BRU_OP_AND           8'h39
`define BRU_OP_OR            8'h3a
`define BRU_OP_XOR           8'h3b
`define BRU_OP_WRAP_INC      8'h3c
`define BRU_OP_WRAP_DEC      8'h3d
`define BRU_OP_FCMPXCHG      8'h3e
`define BRU_OP_FMIN          8'h3f
`define BRU_OP_FMAX          8'h40

// 64-bit atomics
`define BRU_OP_XCHG_W        8'h50
`define BRU_OP_CMPXCHG_W     8'h51
`define BRU_OP_SUM_W         8'h52
`define BRU_OP_DIFF_W        8'h53
`define BRU_OP_SMIN_W        8'h55
`define BRU_OP_UMIN_W        8'h56
`define BRU_OP_SMAX_W        8'h57
`define BRU_OP_UMAX_W        8'h58
`define BRU_OP_AND_W         8'h59
`define BRU_OP_OR_W          8'h5a
`define BRU_OP_XOR_W         8'h5b
`define BRU_OP_WIDE_FIRST    8'h50

// Memory access sizes
`define BRU_SZ_BYTE          2'h0
`define BRU_SZ_HALF          2'h1
`define BRU_SZ_WORD          2'h2
`define BRU_SZ_DWORD         2'h3

// Reset values
`define BRU_RST_WORD         32'h0000_0000
`define BRU_RST_DWORD        64'h0000_0000_0000_0000

`endif

/* File: bru_pkg.sv */
// Types shared by the buffer atomic unit
package bru_pkg;

   typedef enum logic [2:0]
   {
      BRU_IDLE,
      BRU_ISSUE,
      BRU_READ,
      BRU_WRITE,
      BRU_RESP
   } bru_state_t;

endpackage

/* File: bru_alu.sv */
// Modify stage of the atomic read-modify-write operations
`timescale 1ns/1ps
`include "bru_consts.svh"

module bru_alu
(
   // Operation
   input  wire logic [7:0]  i_op,
   // Old memory value and operands
   input  wire logic [63:0] i_old,
   input  wire logic [31:0] i_data0,
   input  wire logic [31:0] i_data1,
   input  wire logic [31:0] i_data2,
   input  wire logic [31:0] i_data3,
   // Result
   output logic      [63:0] o_new,
   output logic             o_known
);

   logic        wide;
   logic [63:0] opa;
   logic [63:0] opb;
   logic [63:0] sum;
   logic [63:0] diff;
   logic [63:0] cmpv;
   logic        s_less;
   logic        s_more;
   logic        u_less;
   logic        u_more;
   logic        old_is_zero;
   logic [31:0] key_old;
   logic [31:0] key_src;
   logic        nan_old;
   logic        nan_src;
   logic        nan_cmp;
   logic        zero_pair;
   logic        f_less;
   logic        f_more;
   logic        f_equal;

   // Operands at the width of the operation
   assign wide   = i_op >= `BRU_OP_WIDE_FIRST;
   assign opa    = wide ? i_old : {32'h0, i_old[31:0]};
   assign opb    = wide ? {i_data1, i_data0} : {32'h0, i_data0};
   assign cmpv   = wide ? {i_data3, i_data2} : {32'h0, i_data1};
   assign sum    = opa + opb;
   assign diff   = opa - opb;
   assign u_less = opb < opa;
   assign u_more = opb > opa;
   assign s_less = wide ? ($signed(opb) < $signed(opa))
                        : ($signed(i_data0) < $signed(i_old[31:0]));
   assign s_more = wide ? ($signed(opb) > $signed(opa))
                        : ($signed(i_data0) > $signed(i_old[31:0]));
   assign old_is_zero = opa == 64'h0;

   // Float ordering keys, NaN and signed zero handling
   assign key_old = i_old[31] ? ~i_old[31:0] : {1'b1, i_old[30:0]};
   assign key_src = i_data0[31] ? ~i_data0 : {1'b1, i_data0[30:0]};
   assign nan_old = (i_old[30:23] == 8'hff) && (i_old[22:0] != 23'h0);
   assign nan_src = (i_data0[30:23] == 8'hff) && (i_data0[22:0] != 23'h0);
   assign nan_cmp = (i_data1[30:23] == 8'hff) && (i_data1[22:0] != 23'h0);
   assign zero_pair = (i_old[30:0] | i_data0[30:0]) == 31'h0;
   assign f_less  = !nan_src &&
                    (nan_old || (!zero_pair && (key_src < key_old)));
   assign f_more  = !nan_src &&
                    (nan_old || (!zero_pair && (key_src > key_old)));
   assign f_equal = !nan_old && !nan_cmp &&
                    ((i_old[31:0] == i_data1) ||
                     ((i_old[30:0] | i_data1[30:0]) == 31'h0));

   always_comb
   begin
      o_new   = i_old;
      o_known = 1'b1;
      case (i_op)
         `BRU_OP_XCHG, `BRU_OP_XCHG_W:
            o_new = opb;
         `BRU_OP_CMPXCHG, `BRU_OP_CMPXCHG_W:
            o_new = (opa == cmpv) ? opb : opa;
         `BRU_OP_SUM, `BRU_OP_SUM_W:
            o_new = sum;
         `BRU_OP_DIFF, `BRU_OP_DIFF_W:
            o_new = diff;
         `BRU_OP_CLAMP_DIFF:
            o_new = u_more ? 64'h0 : diff;
         `BRU_OP_SMIN, `BRU_OP_SMIN_W:
            o_new = s_less ? opb : opa;
         `BRU_OP_SMAX, `BRU_OP_SMAX_W:
            o_new = s_more ? opb : opa;
         `BRU_OP_UMIN, `BRU_OP_UMIN_W:
            o_new = u_less ? opb : opa;
         `BRU_OP_UMAX, `BRU_OP_UMAX_W:
            o_new = u_more ? opb : opa;
         `BRU_OP_AND, `BRU_OP_AND_W:
            o_new = opa & opb;
         `BRU_OP_OR, `BRU_OP_OR_W:
            o_new = opa | opb;
         `BRU_OP_XOR, `BRU_OP_XOR_W:
            o_new = opa ^ opb;
         `BRU_OP_WRAP_INC:
            o_new = (opa >= opb) ? 64'h0
                    : {32'h0, opa[31:0] + 32'h1};
         `BRU_OP_WRAP_DEC:
            o_new = (old_is_zero || u_less) ? opb
                    : {32'h0, opa[31:0] - 32'h1};
         `BRU_OP_FCMPXCHG:
            o_new = f_equal ? opb : opa;
         `BRU_OP_FMIN:
            o_new = f_less ? opb : opa;
         `BRU_OP_FMAX:
            o_new = f_more ? opb : opa;
         default:
            o_known = 1'b0;
      endcase
   end

endmodule

/* File: bru_unit_props.sv */
// Port checker for the buffer atomic unit
`timescale 1ns/1ps
`include "bru_consts.svh"
module bru_unit_props
(
   // Clock and reset
   input wire logic        i_mclk,
   input wire logic        i_rst,
   // Core side
   input wire logic        i_req_valid,
   input wire logic [7:0]  i_req_op,
   input wire logic [31:0] i_req_data0,
   input wire logic [31:0] i_req_dst,
   input wire logic        o_req_ready,
   input wire logic        o_resp_valid,
   input wire logic        o_resp_bad,
   input wire logic [31:0] o_resp_data0,
   // Memory side
   input wire logic        o_mem_rd,
   input wire logic        o_mem_wr,
   input wire logic        o_mem_lock,
   input wire logic [31:0] o_mem_addr,
   input wire logic [1:0]  o_mem_size,
   input wire logic [63:0] o_mem_wdata,
   input wire logic        i_mem_ack,
   input wire logic [63:0] i_mem_rdata
);
   logic [7:0]  op;
   logic [31:0] d0;
   logic [31:0] dst;
   logic [63:0] old;
   wire         acc   = i_req_valid && o_req_ready;
   wire         rdack = o_mem_rd && i_mem_ack;
   wire         known = (i_req_op >= 8'h23 && i_req_op <= 8'h27) ||
                        (i_req_op >= 8'h30 && i_req_op <= 8'h40) ||
                        (i_req_op >= 8'h50 && i_req_op <= 8'h5b &&
                         i_req_op != 8'h54);

   // Request and old value capture
   always_ff @(posedge i_mclk or posedge i_rst)
      if (i_rst)
      begin
         op  <= 8'h00;
         d0  <= 32'h0;
         dst <= 32'h0;
         old <= 64'h0;
      end
      else
      begin
         if (acc)
         begin
            op  <= i_req_op;
            d0  <= i_req_data0;
            dst <= i_req_dst;
         end
         if (rdack)
            old <= i_mem_rdata;
      end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   property p_rd_hold;
      o_mem_rd && !i_mem_ack |=> o_mem_rd && $stable(o_mem_addr);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read dropped early");

   property p_rmw_lock;
      rdack && op >= 8'h30 |=> o_mem_wr && o_mem_lock && $stable(o_mem_addr);
   endproperty
   a_rmw_lock: assert property (p_rmw_lock)
      else $error("atomic write not locked to its read");

   property p_xchg;
      o_mem_wr && op == 8'h30 |-> o_mem_wdata[31:0] == d0 &&
                                  o_mem_size == `BRU_SZ_WORD;
   endproperty
   a_xchg: assert property (p_xchg)
      else $error("exchange data wrong");

   property p_sum;
      o_mem_wr && op == 8'h32 |-> o_mem_wdata[31:0] == old[31:0] + d0;
   endproperty
   a_sum: assert property (p_sum) else $error("sum data wrong");

   property p_store_hi;
      o_mem_wr && op == 8'h27 |-> o_mem_wdata[15:0] == d0[31:16];
   endproperty
   a_store_hi: assert property (p_store_hi)
      else $error("store half wrong");

   property p_half_low;
      o_resp_valid && op == 8'h24 |-> o_resp_data0 == {dst[31:16], old[15:0]};
   endproperty
   a_half_low: assert property (p_half_low)
      else $error("low half load wrong");

   property p_sbyte;
      o_resp_valid && op == 8'h23 |->
         o_resp_data0 == {{8{old[7]}}, old[7:0], dst[15:0]};
   endproperty
   a_sbyte: assert property (p_sbyte)
      else $error("signed byte load wrong");

   property p_bad;
      acc && !known |-> ##[2:3] o_resp_valid && o_resp_bad;
   endproperty
   a_bad: assert property (p_bad) else $error("unknown op not refused");

   property p_resp;
      o_resp_valid |=> !o_resp_valid && o_req_ready;
   endproperty
   a_resp: assert property (p_resp) else $error("response not a pulse");

   property p_busy;
      acc |=> !o_req_ready;
   endproperty
   a_busy: assert property (p_busy) else $error("ready after accept");

   c_rmw: cover property (rdack && o_mem_lock);
   c_bad: cover property (acc && !known);
   c_wait: cover property (o_mem_wr && !i_mem_ack);
endmodule

bind bru_unit bru_unit_props u_props
(
   .i_mclk, .i_rst, .i_req_valid, .i_req_op, .i_req_data0, .i_req_dst,
   .o_req_ready, .o_resp_valid, .o_resp_bad, .o_resp_data0, .o_mem_rd,
   .o_mem_wr, .o_mem_lock, .o_mem_addr, .o_mem_size, .o_mem_wdata,
   .i_mem_ack, .i_mem_rdata
);

/* File: bru_mem_model.sv */
// Behavioural memory answering the unit after a random wait
`timescale 1ns/1ps
module bru_mem_model
(
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   // Request from the unit
   input  wire logic        i_rd,
   input  wire logic        i_wr,
   input  wire logic [31:0] i_addr,
   input  wire logic [1:0]  i_size,
   input  wire logic [63:0] i_wdata,
   // Answer
   output logic             o_ack,
   output logic      [63:0] o_rdata
);
   logic [63:0] mem [logic [31:0]];
   logic [63:0] m;
   logic [63:0] mk;
   integer      seed = 32'h1c5a39e7;
   int          wait_n = 0;

   initial
   begin
      o_ack = 1'b0;
      o_rdata = 64'h0;
   end

   // Idle data bus shows a changing pattern
   always @(negedge i_mclk)
   begin
      o_ack <= 1'b0;
      o_rdata <= {$random(seed), $random(seed)};
      if ((i_rd || i_wr) && !i_rst)
      begin
         if (wait_n == 0)
         begin
            m = mem.exists(i_addr) ? mem[i_addr] : 64'h0;
            mk = (i_size == 2'h0) ? 64'hff : (i_size == 2'h1) ? 64'hffff :
                 (i_size == 2'h2) ? 64'hffff_ffff : {64{1'b1}};
            if (i_wr)
               mem[i_addr] = (m & ~mk) | (i_wdata & mk);
            o_ack <= 1'b1;
            if (i_rd)
               o_rdata <= m;
            wait_n = {$random(seed)} % 4;
         end
         else
            wait_n = wait_n - 1;
      end
   end
endmodule

/* File: bru_unit_tb.sv */
// Self-checking bench for the buffer atomic unit
`timescale 1ns/1ps
module bru_unit_tb;
   logic        i_mclk;
   logic        i_rst;
   logic        i_req_valid;
   logic [7:0]  i_req_op;
   logic [31:0] i_req_addr;
   logic [31:0] i_req_data0;
   logic [31:0] i_req_data1;
   logic [31:0] i_req_data2;
   logic [31:0] i_req_data3;
   logic [31:0] i_req_dst;
   logic        o_req_ready;
   logic        o_resp_valid;
   logic        o_resp_bad;
   logic [31:0] o_resp_data0;
   logic [31:0] o_resp_data1;
   logic        o_mem_rd;
   logic        o_mem_wr;
   logic        o_mem_lock;
   logic [31:0] o_mem_addr;
   logic [1:0]  o_mem_size;
   logic [63:0] o_mem_wdata;
   logic        i_mem_ack;
   logic [63:0] i_mem_rdata;
   integer      seed = 32'h8ec37f03;
   int          num_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;

   bru_unit dut
   (
      .i_mclk, .i_rst, .i_req_valid, .i_req_op, .i_req_addr, .i_req_data0,
      .i_req_data1, .i_req_data2, .i_req_data3, .i_req_dst, .o_req_ready,
      .o_resp_valid, .o_resp_bad, .o_resp_data0, .o_resp_data1, .o_mem_rd,
      .o_mem_wr, .o_mem_lock, .o_mem_addr, .o_mem_size, .o_mem_wdata,
      .i_mem_ack, .i_mem_rdata
   );

   bru_mem_model u_mem
   (
      .i_mclk, .i_rst, .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_addr(o_mem_addr),
      .i_size(o_mem_size), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack),
      .o_rdata(i_mem_rdata)
   );

   initial
   begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   task final_report;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         final_report;
      end
   end

   task chk(input string s, input logic [63:0] e, input logic [63:0] g);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask

   function automatic logic fnan(input logic [31:0] a);
      return a[30:23] == 8'hff && a[22:0] != 23'h0;
   endfunction

   function automatic logic flt(input logic [31:0] a, input logic [31:0] b);
      if (a[30:0] == 31'h0 && b[30:0] == 31'h0)
         return 1'b0;
      if (a[31] != b[31])
         return a[31];
      return a[31] ? a[30:0] > b[30:0] : a[30:0] < b[30:0];
   endfunction

   // One request against the reference, then compare all results
   task automatic run(input logic [7:0] c, input logic eq);
      logic [63:0] old, nm, q, s, cp;
      logic [31:0] a, x0, x1, y, t, n, r, r1;
      logic        bad;
      int          k;
      a = $random(seed);
      old = {$random(seed), $random(seed)};
      x0 = $random(seed);
      {x1, cp} = {$random(seed), $random(seed), $random(seed)};
      y = $random(seed);
      if (eq)
         {x1, cp} = {old[31:0], old};
      u_mem.mem[a] = old;
      t = old[31:0];
      s = {x1, x0};
      {n, q, nm, r, r1, bad} = {t, old, old, 32'h0, 32'h0, 1'b0};
      case (c)
         8'h23: r = {{8{t[7]}}, t[7:0], y[15:0]};
         8'h24: r = {y[31:16], t[15:0]};
         8'h25, 8'h26: r = {t[15:0], y[15:0]};
         8'h27: nm[15:0] = x0[31:16];
         8'h30: n = x0;
         8'h31: n = (t == x1) ? x0 : t;
         8'h32: n = t + x0;
         8'h33: n = t - x0;
         8'h34: n = (t < x0) ? 32'h0 : t - x0;
         8'h35: n = ($signed(x0) < $signed(t)) ? x0 : t;
         8'h36: n = (x0 < t) ? x0 : t;
         8'h37: n = ($signed(x0) > $signed(t)) ? x0 : t;
         8'h38: n = (x0 > t) ? x0 : t;
         8'h39: n = t & x0;
         8'h3a: n = t | x0;
         8'h3b: n = t ^ x0;
         8'h3c: n = (t >= x0) ? 32'h0 : t + 1;
         8'h3d: n = (t == 0 || t > x0) ? x0 : t - 1;
         8'h3e: n = (!fnan(t) && !fnan(x1) && !flt(t, x1) && !flt(x1, t)) ?
                    x0 : t;
         8'h3f: n = fnan(x0) ? t : fnan(t) ? x0 :
                    flt(x0, t) ? x0 : t;
         8'h40: n = fnan(x0) ? t : fnan(t) ? x0 :
                    flt(t, x0) ? x0 : t;
         8'h50: q = s;
         8'h51: q = (old == cp) ? s : old;
         8'h52: q = old + s;
         8'h53: q = old - s;
         8'h55: q = ($signed(s) < $signed(old)) ? s : old;
         8'h56: q = (s < old) ? s : old;
         8'h57: q = ($signed(s) > $signed(old)) ? s : old;
         8'h58: q = (s > old) ? s : old;
         8'h59: q = old & s;
         8'h5a: q = old | s;
         8'h5b: q = old ^ s;
         default: bad = 1'b1;
      endcase
      if (c >= 8'h30 && c <= 8'h40)
         {nm, r} = {old[63:32], n, t};
      if (c >= 8'h50 && !bad)
         {nm, r1, r} = {q, old};
      @(negedge i_mclk);
      while (!o_req_ready)
         @(negedge i_mclk);
      {i_req_valid, i_req_op, i_req_addr, i_req_dst} = {1'b1, c, a, y};
      {i_req_data3, i_req_data2, i_req_data1, i_req_data0} = {cp, s};
      @(negedge i_mclk);
      i_req_valid = 1'b0;
      {i_req_op, i_req_data0} = {8'h00, $random(seed)};
      k = 0;
      while (!o_resp_valid && k < 60)
      begin
         @(negedge i_mclk);
         k++;
      end
      chk("resp_valid", 1, o_resp_valid);
      chk("resp_bad", bad, o_resp_bad);
      chk("resp_data0", r, o_resp_data0);
      chk("resp_data1", r1, o_resp_data1);
      chk("memory", nm, u_mem.mem[a]);
   endtask

   initial
   begin
      {i_rst, i_req_valid, i_req_op, i_req_addr} = {1'b1, 1'b0, 8'h00, 32'h0};
      {i_req_data0, i_req_data1, i_req_data2, i_req_data3} = 128'h0;
      i_req_dst = 32'h0;
      repeat (12) @(negedge i_mclk);
      i_rst = 1'b0;
      for (int rep = 0; rep < 4; rep++)
      begin
         for (int c = 32; c < 96; c++)
            run(c[7:0], rep[0]);
         i_rst = 1'b1;
         @(negedge i_mclk);
         chk("ready in reset", 1, o_req_ready);
         chk("resp in reset", 0, o_resp_valid);
         i_rst = 1'b0;
      end
      repeat (16) run(8'($random(seed)), 1'b0);
      final_report;
   end
endmodule
